// ==== pkg/ext_bus_regs.svh ====
// Constants of the external memory bus interface
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH
`define OSC_PERIOD_NS      5
`define CLK_PERIOD_NS      5
`define OSC_TO_CLK(n)      (((n) * `OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MACHINE_OSC        12
`define MACHINE_CLKS       `OSC_TO_CLK(`MACHINE_OSC)
`define SLOT_CLKS          (`MACHINE_CLKS / 2)
`define ALE_HIGH_CLKS      2
`define ADDR_HOLD_CLKS     3
`define FETCH_STROBE_CLKS  `OSC_TO_CLK(3)
`define READ_STROBE_CLKS   `OSC_TO_CLK(6)
`define INT_CODE_TOP       16'h1FFF
`define PORT0_LATCH_ONES   8'hFF
`endif

// ==== pkg/ext_bus_pkg.sv ====
// Types shared by the external memory bus interface
package ext_bus_pkg;
  typedef enum logic [1:0] {MC_FETCH, MC_MOVE1, MC_MOVE2} mc_state_type;
  typedef enum logic [1:0] {SK_FETCH, SK_ADDR, SK_STROBE, SK_TAIL} slot_kind_type;
  typedef struct packed {
    logic       ale;
    logic       programFetchStrobeN;
    logic       dataReadStrobeN;
    logic       dataWriteStrobeN;
    logic [7:0] port0Out;
    logic       port0Oe;
    logic [7:0] port2Out;
    logic [7:0] port2StrongPullup;
  } bus_pins_type;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        useDataPointer;
    logic [15:0] dataPointer;
    logic [7:0]  indirectIndex;
    logic [7:0]  writeData;
  } move_req_type;
endpackage : ext_bus_pkg

// ==== logic/ext_bus_if.sv ====
// External memory bus interface: machine cycle timing and bus pins
`include "ext_bus_regs.svh"
module ext_bus_if (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 externalAccessSelectN,
  input  wire logic [15:0]          programCounter,
  input  wire logic [7:0]           portTwoLatch,
  input  wire ext_bus_pkg::move_req_type moveReq,
  input  wire logic [7:0]           port0In,
  output ext_bus_pkg::bus_pins_type busPins,
  output logic                      moveAck,
  output logic                      portZeroLatchOnes,
  output logic [7:0]                fetchData,
  output logic                      fetchValid,
  output logic [7:0]                readData,
  output logic                      readValid
);
  localparam logic [3:0] LastPhase = 4'(`MACHINE_CLKS - 1);
  localparam logic [2:0] LastSub   = 3'(`SLOT_CLKS - 1);

  ext_bus_pkg::bus_pins_type  pins_r;
  ext_bus_pkg::bus_pins_type  pins_nxt;
  ext_bus_pkg::mc_state_type  state_r;
  ext_bus_pkg::slot_kind_type kind;
  ext_bus_pkg::move_req_type  move_r;
  logic [3:0]  phase_r;
  logic [2:0]  sub;
  logic        half;
  logic [1:0]  selSync_r;
  logic [7:0]  p0Meta_r;
  logic [7:0]  p0Sync_r;
  logic [15:0] slotAddr_r;
  logic [15:0] slotAddr;
  logic        slotExt_r;
  logic        slotExt;
  logic        busUsed;
  logic        moveAck_r;
  logic        latchOnes_r;
  logic [7:0]  fetchData_r;
  logic        fetchValid_r;
  logic        fetchDue_r;
  logic [7:0]  readData_r;
  logic        readValid_r;

  // Pins from outside pass two flip-flops first
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      selSync_r <= 2'b11;
      p0Meta_r  <= 8'h00;
      p0Sync_r  <= 8'h00;
    end else begin
      selSync_r <= {selSync_r[0], externalAccessSelectN};
      p0Meta_r  <= port0In;
      p0Sync_r  <= p0Meta_r;
    end
  end

  // Machine cycle of twelve clocks, two slots of six
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_r <= 4'h0;
    end else if (phase_r == LastPhase) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_r + 4'h1;
    end
  end

  assign half = (phase_r >= 4'(`SLOT_CLKS));
  assign sub  = half ? 3'(phase_r - 4'(`SLOT_CLKS)) : phase_r[2:0];

  // Cycle sequencer; a data move takes two machine cycles
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r   <= ext_bus_pkg::MC_FETCH;
      move_r    <= '0;
      moveAck_r <= 1'b0;
    end else begin
      moveAck_r <= 1'b0;
      if (phase_r == LastPhase) begin
        case (state_r)
          ext_bus_pkg::MC_MOVE1: begin
            state_r <= ext_bus_pkg::MC_MOVE2;
          end
          default: begin
            if (moveReq.valid) begin
              state_r   <= ext_bus_pkg::MC_MOVE1;
              move_r    <= moveReq;
              moveAck_r <= 1'b1;
            end else begin
              state_r <= ext_bus_pkg::MC_FETCH;
            end
          end
        endcase
      end
    end
  end

  // Slot kind; fetch strobe left out of all move slots but the first
  always_comb begin
    case (state_r)
      ext_bus_pkg::MC_FETCH: kind = ext_bus_pkg::SK_FETCH;
      ext_bus_pkg::MC_MOVE1: kind = half ? ext_bus_pkg::SK_ADDR : ext_bus_pkg::SK_FETCH;
      ext_bus_pkg::MC_MOVE2: kind = half ? ext_bus_pkg::SK_TAIL : ext_bus_pkg::SK_STROBE;
      default:               kind = ext_bus_pkg::SK_FETCH;
    endcase
  end

  // Slot address and external flag, caught at slot start
  always_comb begin
    if (sub == 3'h0) begin
      if (kind == ext_bus_pkg::SK_FETCH) begin
        slotAddr = programCounter;
        slotExt  = !selSync_r[1] || (programCounter > `INT_CODE_TOP);
      end else begin
        slotAddr = move_r.useDataPointer ? move_r.dataPointer
                                         : {portTwoLatch, move_r.indirectIndex};
        slotExt  = 1'b1;
      end
    end else begin
      slotAddr = slotAddr_r;
      slotExt  = slotExt_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      slotAddr_r <= 16'h0000;
      slotExt_r  <= 1'b0;
    end else begin
      slotAddr_r <= slotAddr;
      slotExt_r  <= slotExt;
    end
  end

  assign busUsed = slotExt && (kind != ext_bus_pkg::SK_TAIL);

  // Next pin values; registered so every pin leaves a flip-flop
  always_comb begin
    pins_nxt                     = '0;
    pins_nxt.programFetchStrobeN = 1'b1;
    pins_nxt.dataReadStrobeN     = 1'b1;
    pins_nxt.dataWriteStrobeN    = 1'b1;
    pins_nxt.port2Out            = portTwoLatch;
    // Latch strobe every slot except the strobe slot
    pins_nxt.ale = (sub < 3'(`ALE_HIGH_CLKS)) && (kind != ext_bus_pkg::SK_STROBE);
    // Low address held past the strobe's falling edge
    if (busUsed && (sub < 3'(`ADDR_HOLD_CLKS)) && (kind != ext_bus_pkg::SK_STROBE)) begin
      pins_nxt.port0Out = slotAddr[7:0];
      pins_nxt.port0Oe  = 1'b1;
    end
    case (kind)
      ext_bus_pkg::SK_FETCH: begin
        if (slotExt) begin
          pins_nxt.programFetchStrobeN = (sub < 3'(`SLOT_CLKS - `FETCH_STROBE_CLKS));
        end
      end
      ext_bus_pkg::SK_ADDR: begin
        if (move_r.write && (sub >= 3'(`ADDR_HOLD_CLKS))) begin
          pins_nxt.port0Out = move_r.writeData;
          pins_nxt.port0Oe  = 1'b1;
        end
      end
      ext_bus_pkg::SK_STROBE: begin
        pins_nxt.dataReadStrobeN  = move_r.write;
        pins_nxt.dataWriteStrobeN = !move_r.write;
        if (move_r.write) begin
          pins_nxt.port0Out = move_r.writeData;
          pins_nxt.port0Oe  = 1'b1;
        end
      end
      ext_bus_pkg::SK_TAIL: begin
        // Write data outlives the write strobe by one clock
        if (move_r.write && (sub == 3'h0)) begin
          pins_nxt.port0Out = move_r.writeData;
          pins_nxt.port0Oe  = 1'b1;
        end
      end
      default: begin
        pins_nxt.port0Oe = 1'b0;
      end
    endcase
    // High byte held on port two for the whole external cycle
    if ((kind == ext_bus_pkg::SK_FETCH && slotExt) || (kind != ext_bus_pkg::SK_FETCH && move_r.useDataPointer)) begin
      pins_nxt.port2Out          = slotAddr[15:8];
      pins_nxt.port2StrongPullup = slotAddr[15:8];
    end else if (kind != ext_bus_pkg::SK_FETCH) begin
      pins_nxt.port2Out = portTwoLatch;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pins_r                     <= '0;
      pins_r.programFetchStrobeN <= 1'b1;
      pins_r.dataReadStrobeN     <= 1'b1;
      pins_r.dataWriteStrobeN    <= 1'b1;
      pins_r.port2Out            <= `PORT0_LATCH_ONES;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // Port zero latch forced to ones at each external access
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      latchOnes_r <= 1'b0;
    end else begin
      latchOnes_r <= busUsed && (sub == 3'h0);
    end
  end

  // Capture from the synchronised pins, two clocks behind the bus.
  // Read strobe is six clocks, so the read is taken on its last clock;
  // the fetch strobe is only three, so its byte lands on the clock it rises
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fetchData_r  <= 8'h00;
      fetchValid_r <= 1'b0;
      fetchDue_r   <= 1'b0;
      readData_r   <= 8'h00;
      readValid_r  <= 1'b0;
    end else begin
      fetchValid_r <= 1'b0;
      readValid_r  <= 1'b0;
      fetchDue_r   <= (sub == LastSub) && (kind == ext_bus_pkg::SK_FETCH) && slotExt;
      if (fetchDue_r) begin
        fetchData_r  <= p0Sync_r;  // Pin level of the first strobe clock
        fetchValid_r <= 1'b1;
      end
      if (sub == LastSub && kind == ext_bus_pkg::SK_STROBE && !move_r.write) begin
        readData_r  <= p0Sync_r;
        readValid_r <= 1'b1;
      end
    end
  end

  assign busPins           = pins_r;
  assign moveAck           = moveAck_r;
  assign portZeroLatchOnes = latchOnes_r;
  assign fetchData         = fetchData_r;
  assign fetchValid        = fetchValid_r;
  assign readData          = readData_r;
  assign readValid         = readValid_r;

  // Clocks since the latch strobe was last high; once at 16 it no longer clears and runs on to 31
  logic [4:0] aleGap_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || (pins_r.ale && !aleGap_r[4])) begin
      aleGap_r <= 5'h0;
    end else if (aleGap_r != 5'h1F) begin
      aleGap_r <= aleGap_r + 5'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  strobe_exclusive_a: assert property (!pins_r.programFetchStrobeN |-> pins_r.dataReadStrobeN && pins_r.dataWriteStrobeN)
    else $error("fetch strobe overlaps a data strobe");
  ale_suppressed_a: assert property ((!pins_r.dataReadStrobeN || !pins_r.dataWriteStrobeN) |-> !pins_r.ale)
    else $error("latch strobe during data strobe");
  read_width_a: assert property ($fell(pins_r.dataReadStrobeN) |-> (!pins_r.dataReadStrobeN)[*6] ##1 pins_r.dataReadStrobeN)
    else $error("read strobe not six clocks");
  fetch_width_a: assert property ($fell(pins_r.programFetchStrobeN) |->
                                  (!pins_r.programFetchStrobeN)[*3] ##1 pins_r.programFetchStrobeN)
    else $error("fetch strobe not three clocks");
  ale_shape_a: assert property ($rose(pins_r.ale) |-> pins_r.ale[*2] ##1 !pins_r.ale[*4])
    else $error("latch strobe shape wrong");
  ale_gap_a: assert property (aleGap_r <= 5'd12)
    else $error("latch strobe missing too long");
  addr_at_fall_a: assert property ($fell(pins_r.ale) && $past(pins_r.port0Oe) |-> pins_r.port0Oe && $stable(pins_r.port0Out))
    else $error("low address not valid at strobe fall");
  write_hold_a: assert property ($rose(pins_r.dataWriteStrobeN) |-> pins_r.port0Oe && $stable(pins_r.port0Out))
    else $error("write data not held past strobe");
  write_setup_a: assert property ($fell(pins_r.dataWriteStrobeN) |-> $past(pins_r.port0Oe))
    else $error("write data not ahead of strobe");
  read_capture_a: assert property (readValid_r |-> !pins_r.dataReadStrobeN ##1 pins_r.dataReadStrobeN)
    else $error("read captured outside strobe");
  // Write data held into the next slot is not an access
  latch_ones_a: assert property (
    $rose(pins_r.ale) && pins_r.port0Oe && $past(pins_r.dataWriteStrobeN) |-> latchOnes_r)
    else $error("port zero latch not set to ones");
  high_hold_a: assert property (!pins_r.dataReadStrobeN && $past(!pins_r.dataReadStrobeN) |-> $stable(pins_r.port2Out))
    else $error("port two changed during read");
  internal_fetch_a: assert property (!pins_r.programFetchStrobeN |-> $past(slotExt_r))
    else $error("fetch strobe on internal fetch");

  // Port two during data strobes, by addressing form; port zero low byte at the move's latch strobe fall
  index_page_a: assert property (
    (!pins_r.dataReadStrobeN || !pins_r.dataWriteStrobeN) && !move_r.useDataPointer |->
    pins_r.port2Out == $past(portTwoLatch) && pins_r.port2StrongPullup == 8'h00)
    else $error("port two not showing its latch on a paged move");
  pointer_high_a: assert property (
    (!pins_r.dataReadStrobeN || !pins_r.dataWriteStrobeN) && move_r.useDataPointer |->
    pins_r.port2Out == move_r.dataPointer[15:8])
    else $error("port two not showing pointer high byte");
  pointer_pullup_a: assert property (
    (!pins_r.dataReadStrobeN || !pins_r.dataWriteStrobeN) && move_r.useDataPointer |->
    pins_r.port2StrongPullup == move_r.dataPointer[15:8])
    else $error("strong pull-up missing on address ones");
  move_low_a: assert property (
    $fell(pins_r.ale) && (state_r == ext_bus_pkg::MC_MOVE1) && half |->
    pins_r.port0Out == (move_r.useDataPointer ? move_r.dataPointer[7:0] : move_r.indirectIndex))
    else $error("move address low byte wrong at strobe fall");

  // Fetch routing, decided at slot start, seen on the pins four clocks on
  ext_fetch_a: assert property (
    (sub == 3'h0) && (kind == ext_bus_pkg::SK_FETCH) && (!selSync_r[1] || programCounter > `INT_CODE_TOP) |->
    ##4 !pins_r.programFetchStrobeN)
    else $error("external fetch without fetch strobe");
  int_fetch_quiet_a: assert property (
    (sub == 3'h0) && (kind == ext_bus_pkg::SK_FETCH) && selSync_r[1] && (programCounter <= `INT_CODE_TOP) |->
    ##4 pins_r.programFetchStrobeN)
    else $error("fetch strobe on on-chip fetch");
  move_no_fetch_a: assert property (
    (state_r == ext_bus_pkg::MC_MOVE2) || ((state_r == ext_bus_pkg::MC_MOVE1) && half) |=>
    pins_r.programFetchStrobeN)
    else $error("fetch strobe inside a data move");
  fetch_high_a: assert property (
    !pins_r.programFetchStrobeN |-> $stable(pins_r.port2Out))
    else $error("port two moved during fetch strobe");
  fetch_pullup_a: assert property (
    !pins_r.programFetchStrobeN |-> pins_r.port2StrongPullup == pins_r.port2Out)
    else $error("strong pull-up differs from fetch address");

  // Latch strobe dropped in the strobe slot; cycle length
  first_ale_gone_a: assert property (
    (state_r == ext_bus_pkg::MC_MOVE2) && !half |=> !pins_r.ale)
    else $error("latch strobe in move strobe slot");
  phase_wrap_a: assert property (phase_r == LastPhase |=> phase_r == 4'h0)
    else $error("machine cycle not twelve clocks");

  read_move_c: cover property ($rose(readValid_r));
  write_move_c: cover property ($rose(pins_r.dataWriteStrobeN));
  ext_fetch_c: cover property (fetchValid_r);
  index_move_c: cover property (moveAck_r && !move_r.useDataPointer);
  paged_read_c: cover property (readValid_r && !move_r.useDataPointer);
endmodule : ext_bus_if

// ==== test/ext_mem_model.sv ====
// External memory with address latch facing the bus block
module ext_mem_model (
  input  wire logic                      ref_clk,
  input  wire ext_bus_pkg::bus_pins_type busPins,
  input  wire logic [1:0]                respDelay,
  output logic [7:0]                     port0In,
  output logic [15:0]                    wrAddr,
  output logic [7:0]                     wrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lowLatch = 8'h00;
  logic [7:0] lastLevel = 8'h00;
  logic [2:0] age = 3'h0;
  logic       alePrev = 1'b0;
  logic       wrPrev = 1'b1;
  wire        readLow = !busPins.programFetchStrobeN || !busPins.dataReadStrobeN;
  wire [15:0] addr = {busPins.port2Out, lowLatch};
  // Slow mode withholds the byte for the first strobe clocks
  always_comb begin
    if (busPins.port0Oe) port0In = busPins.port0Out;
    else if (readLow && age >= 3'(respDelay)) port0In = addr[7:0] ^ addr[15:8] ^ 8'h5A;
    else port0In = ~lastLevel; // Released bus must not keep its value
  end
  // Address latch closes on the falling latch strobe
  always @(posedge ref_clk) begin
    alePrev <= busPins.ale;
    wrPrev <= busPins.dataWriteStrobeN;
    lastLevel <= port0In;
    age <= readLow ? age + 3'h1 : 3'h0;
    if (alePrev && !busPins.ale) lowLatch <= port0In;
    if (!wrPrev && busPins.dataWriteStrobeN) begin
      wrAddr <= addr;
      wrData <= port0In;
    end
  end
endmodule : ext_mem_model

// ==== test/external_memory_bus_interface_tb.sv ====
// Self-checking bench for the external memory bus block
module external_memory_bus_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic selN = 1'b1;
  logic [15:0] pc = 16'h0000;
  logic [7:0] p2Latch = 8'hFF;
  ext_bus_pkg::move_req_type req = '0;
  logic [1:0] respDelay = 2'h0;
  wire ext_bus_pkg::bus_pins_type pins;
  logic [7:0] port0In, fetchData, readData, wrData;
  logic [15:0] wrAddr;
  logic moveAck, onesPulse, fetchValid, readValid;
  logic [7:0] p2Exp = 8'h00, puExp = 8'h00, wdExp = 8'h00;
  logic alePrev = 1'b0, wrPrev = 1'b1, okPrev = 1'b0, wrOk;
  int failures = 0, total_checks = 0, cycles = 0;
  int aleRises, psenLow, rdLow, wrLow, fetches, reads, ones, fdBad, pinBad, wrBad;

  ext_bus_if dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .externalAccessSelectN(selN), .programCounter(pc),
    .portTwoLatch(p2Latch), .moveReq(req), .port0In(port0In), .busPins(pins), .moveAck(moveAck),
    .portZeroLatchOnes(onesPulse), .fetchData(fetchData), .fetchValid(fetchValid),
    .readData(readData), .readValid(readValid));
  ext_mem_model mem (.ref_clk(ref_clk), .busPins(pins), .respDelay(respDelay), .port0In(port0In),
    .wrAddr(wrAddr), .wrData(wrData));

  // Free-running oscillator clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Hang guard, well beyond the whole sequence
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      summarize();
    end
  end

  function automatic logic [7:0] memByte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : memByte

  // Pin watcher: strobe clocks and pin faults per scenario
  always @(posedge ref_clk) begin
    aleRises += int'(pins.ale && !alePrev);
    psenLow += int'(!pins.programFetchStrobeN);
    rdLow += int'(!pins.dataReadStrobeN);
    wrLow += int'(!pins.dataWriteStrobeN);
    fetches += int'(fetchValid === 1'b1);
    reads += int'(readValid === 1'b1);
    ones += int'(onesPulse === 1'b1);
    if (fetchValid === 1'b1 && fetchData !== memByte(pc)) fdBad++;
    if (!pins.programFetchStrobeN && pins.port2Out !== pc[15:8]) fdBad++;
    if ((!pins.dataReadStrobeN || !pins.dataWriteStrobeN) &&
        (pins.ale !== 1'b0 || pins.port2Out !== p2Exp || pins.port2StrongPullup !== puExp)) pinBad++;
    wrOk = pins.port0Oe === 1'b1 && pins.port0Out === wdExp;
    if ((!pins.dataWriteStrobeN && !(okPrev && wrOk)) || (!wrPrev && !wrOk)) wrBad++;
    okPrev = wrOk;
    wrPrev = pins.dataWriteStrobeN;
    alePrev = pins.ale;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic run(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : run

  task automatic clear;
    {aleRises, psenLow, rdLow, wrLow, fetches, reads, ones, fdBad, pinBad, wrBad} = '0;
  endtask : clear

  task automatic t_reset;
    check("strobes", 16'h0007, {13'h0000, pins.programFetchStrobeN, pins.dataReadStrobeN, pins.dataWriteStrobeN});
    check("ale oe", 16'h0000, {14'h0000, pins.ale, pins.port0Oe});
    check("port2", 16'h00FF, {8'h00, pins.port2Out});
  endtask : t_reset

  // Settle the select synchroniser, then watch four machine cycles
  task automatic fetch_window(input logic sel, input logic [15:0] addr);
    selN = sel;
    pc = addr;
    run(24);
    clear();
    run(48);
  endtask : fetch_window

  task automatic t_fetch_external;
    fetch_window(1'b0, 16'h1234);
    check("ale rises", 16'h0008, 16'(aleRises));
    check("program_fetch_strobe clocks", 16'h0018, 16'(psenLow));
    check("fetches", 16'h0008, 16'(fetches));
    check("rd wr clocks", 16'h0000, 16'(rdLow + wrLow));
    check("fetch faults", 16'h0000, 16'(fdBad));
    check("ones pulses", 16'h0008, 16'(ones));
  endtask : t_fetch_external

  // Top of on-chip code space stays internal
  task automatic t_fetch_internal;
    fetch_window(1'b1, 16'h1FFF);
    check("ale rises", 16'h0008, 16'(aleRises));
    check("program_fetch_strobe clocks", 16'h0000, 16'(psenLow));
    check("ones pulses", 16'h0000, 16'(ones));
  endtask : t_fetch_internal

  task automatic t_fetch_above;
    fetch_window(1'b1, 16'h2000);
    check("program_fetch_strobe clocks", 16'h0018, 16'(psenLow));
    check("fetch faults", 16'h0000, 16'(fdBad));
  endtask : t_fetch_above

  // Request held until taken, then the move runs out
  task automatic do_move(input logic wr, input logic dp, input logic [15:0] a, input logic [7:0] d);
    int i;
    p2Exp = dp ? a[15:8] : p2Latch;
    puExp = dp ? a[15:8] : 8'h00;
    wdExp = d;
    pc = 16'h0100;  // On-chip fetches, so only the move uses the bus
    req = '{valid: 1'b1, write: wr, useDataPointer: dp, dataPointer: a, indirectIndex: a[7:0], writeData: d};
    clear();
    for (i = 0; i < 40 && moveAck !== 1'b1; i++) run(1);
    req.valid = 1'b0;
    check("taken", 16'h0001, 16'(i < 40));
    run(30);
  endtask : do_move

  task automatic t_write_pointer;
    do_move(1'b1, 1'b1, 16'hA5C3, 8'h3C);
    check("wr clocks", 16'h0006, 16'(wrLow));
    check("rd clocks", 16'h0000, 16'(rdLow));
    check("wr data hold", 16'h0000, 16'(wrBad));
    check("pins", 16'h0000, 16'(pinBad));
    check("wr addr", 16'hA5C3, wrAddr);
    check("wr data", 16'h003C, {8'h00, wrData});
    check("ones seen", 16'h0001, 16'(ones != 0));
  endtask : t_write_pointer

  // Paged read with a slow memory
  task automatic t_read_index;
    p2Latch = 8'h7E;
    respDelay = 2'h1;
    do_move(1'b0, 1'b0, 16'hC319, 8'h00);
    check("rd clocks", 16'h0006, 16'(rdLow));
    check("wr clocks", 16'h0000, 16'(wrLow));
    check("reads", 16'h0001, 16'(reads));
    check("pins", 16'h0000, 16'(pinBad));
    check("rd data", {8'h00, memByte(16'h7E19)}, {8'h00, readData});
  endtask : t_read_index

  task automatic t_read_pointer;
    respDelay = 2'h0;
    do_move(1'b0, 1'b1, 16'hFF00, 8'h00);
    check("pins", 16'h0000, 16'(pinBad));
    check("rd data", {8'h00, memByte(16'hFF00)}, {8'h00, readData});
  endtask : t_read_pointer

  task automatic summarize;
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    run(2);
    t_reset();
    sys_rst = 1'b0;
    t_fetch_external();
    t_fetch_internal();
    t_fetch_above();
    t_write_pointer();
    t_read_index();
    t_read_pointer();
    summarize();
  end
endmodule : external_memory_bus_interface_tb
